// [rtl/rcm_pkg.sv]
package rcm_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATIC_OFF = 8'h04;
  localparam logic [7:0] ADDR_SCALE      = 8'h08;
  localparam logic [7:0] ADDR_MIN_TIME   = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS      = 8'h10;
  localparam logic [7:0] ADDR_ACK        = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT   = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK   = 8'h1C;
  localparam logic [7:0] ADDR_LIMIT      = 8'h20;
  localparam logic [7:0] ADDR_WARN_LIM   = 8'h24;
  localparam logic [7:0] ADDR_THR_BASE   = 8'h40;
  localparam logic [7:0] ADDR_OFF_BASE   = 8'h80;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PCT_LSB  = 8;
  localparam int CTRL_CNT_LSB  = 16;
  localparam int FLAG_WARN     = 0;
  localparam int FLAG_OVER     = 1;
  localparam int FLAG_ALARM    = 2;

  // ****************************************
  // reset values and constants
  // ****************************************
  localparam logic [1:0]  RST_MODE       = 2'h0;
  localparam logic [7:0]  RST_WARN_PCT   = 8'h50;
  localparam logic [3:0]  RST_STEP_CNT   = 4'h0;
  localparam logic [31:0] RST_STATIC_OFF = 32'h0000_012C;
  localparam logic [31:0] RST_SCALE      = 32'h0000_0000;
  localparam logic [31:0] RST_MIN_TIME   = 32'h0000_0000;
  localparam logic [2:0]  RST_INT_MASK   = 3'h0;
  localparam int          PCT_DIV        = 100;
  localparam int          STEPS_MAX      = 10;

  typedef enum logic [1:0] {
    MODE_STATIC  = 2'b00,
    MODE_DYNAMIC = 2'b01,
    MODE_STEP    = 2'b10
  } mode_t;

  typedef struct packed {
    logic alarm;
    logic over;
    logic warn;
  } flags_t;

endpackage : rcm_pkg

// [rtl/rcm_limit_calc.sv]
`timescale 1ns/1ps
module rcm_limit_calc
  import rcm_pkg::*;
#(
  parameter int RW = 16,
  parameter int LW = 32,
  parameter int N  = STEPS_MAX
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [1:0]           mode,
  input  wire logic [RW-1:0]        reference_value,
  input  wire logic [15:0]          scale,
  input  wire logic [LW-1:0]        static_limit_offset,
  input  wire logic [3:0]           step_cnt,
  input  wire logic [N-1:0][RW-1:0] step_thresholds,
  input  wire logic [N-1:0][LW-1:0] step_limit_offsets,
  input  wire logic [7:0]           warn_pct,
  output logic      [LW-1:0]        limit_r,
  output logic      [LW-1:0]        warn_lim_r
);

  logic [LW-1:0] limit_nxt;
  logic [LW-1:0] warn_lim_nxt;
  logic [LW:0]   sum;
  logic [LW+7:0] wprod;
  logic [LW+7:0] wquot;
  logic [LW-1:0] step_off;

  // ****************************************
  // active limit and warning limit
  // ****************************************
  always_comb begin
    step_off = '0;
    for (int i = 0; i < N; i++) begin
      if ((4'(i) < step_cnt) && (reference_value > step_thresholds[i])) begin
        step_off = step_limit_offsets[i]; // [R5] [R7]
      end
    end
    unique case (mode)
      MODE_DYNAMIC: sum = (LW+1)'(reference_value * scale) + {1'b0, static_limit_offset}; // [R2] [R3]
      MODE_STEP:    sum = {1'b0, static_limit_offset} + {1'b0, step_off}; // [R4] [R6]
      default:      sum = {1'b0, static_limit_offset}; // [R1]
    endcase
    limit_nxt    = sum[LW] ? '1 : sum[LW-1:0];
    wprod        = limit_nxt * warn_pct; // [R8]
    wquot        = wprod / (LW+8)'(PCT_DIV);
    warn_lim_nxt = (|wquot[LW+7:LW]) ? '1 : wquot[LW-1:0];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      limit_r    <= '0;
      warn_lim_r <= '0;
    end else begin
      limit_r    <= limit_nxt; // [R16]
      warn_lim_r <= warn_lim_nxt;
    end
  end

endmodule : rcm_limit_calc

// [rtl/residual_current_monitor.sv]
// How it works
// (R1) static mode: fixed limit, ignore reference
// (R2) dynamic mode tracks reference continuously
// (R3) dynamic limit = reference times scale plus offset
// (R4) stepwise table of ten ascending thresholds
// (R5) step limit: offset plus highest exceeded step
// (R6) no steps configured: static offset only
// (R7) step offsets need not be monotonic
// (R8) warning limit is limit times percentage
// (R9) warning flag sets above warning limit
// (R10) warning flag clears at or below, unacknowledged
// (R11) overcurrent flag sets above active limit
// (R12) overcurrent flag clears at or below limit
// (R13) alarm only after exceedance longer than minimum
// (R14) alarm latched until explicit acknowledge write
// (R15) timer restarts when overcurrent ends early
// (R16) strict greater compare, limits computed first
`timescale 1ns/1ps
module residual_current_monitor
  import rcm_pkg::*;
#(
  parameter int CW = 16,
  parameter int RW = 16,
  parameter int LW = 32,
  parameter int N  = STEPS_MAX
) (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [CW-1:0] residual_current,
  input  wire logic [RW-1:0] reference_value,
  output logic               warn_flag,
  output logic               over_flag,
  output logic               alarm_flag,
  output logic               irq
);

  // ****************************************
  // configuration registers
  // ****************************************
  logic [1:0]           mode_r,     mode_nxt;
  logic [7:0]           pct_r,      pct_nxt;
  logic [3:0]           cnt_r,      cnt_nxt;
  logic [LW-1:0]        soff_r,     soff_nxt;
  logic [15:0]          scale_r,    scale_nxt;
  logic [31:0]          min_r,      min_nxt;
  logic [N-1:0][RW-1:0] thr_r,      thr_nxt;
  logic [N-1:0][LW-1:0] off_r,      off_nxt;
  logic [2:0]           istat_r,    istat_nxt;
  logic [2:0]           imask_r,    imask_nxt;
  logic                 irq_r,      irq_nxt;
  logic [31:0]          prdata_r,   prdata_nxt;
  logic                 pready_r,   pready_nxt;
  logic                 pslverr_r,  pslverr_nxt;
  flags_t               flags_r,    flags_nxt;
  logic [31:0]          tmr_r,      tmr_nxt;
  logic [LW-1:0]        limit;
  logic [LW-1:0]        warn_lim;
  logic                 acc;
  logic                 wr;
  logic                 ack;
  logic [2:0]           events;
  logic                 mapped;

  assign acc    = psel & penable & pready_r;
  assign wr     = acc & pwrite;
  assign ack    = wr && (paddr == ADDR_ACK) && pwdata[0];
  assign events = flags_nxt & ~flags_r;

  // ****************************************
  // limit computation
  // ****************************************
  rcm_limit_calc #(
    .RW (RW),
    .LW (LW),
    .N  (N)
  ) u_limit (
    .core_clk            (core_clk),
    .rst                 (rst),
    .mode                (mode_r),
    .reference_value     (reference_value),
    .scale               (scale_r),
    .static_limit_offset (soff_r),
    .step_cnt            (cnt_r),
    .step_thresholds     (thr_r),
    .step_limit_offsets  (off_r),
    .warn_pct            (pct_r),
    .limit_r             (limit),
    .warn_lim_r          (warn_lim)
  );

  // ****************************************
  // flags and minimum exceedance timer
  // ****************************************
  always_comb begin
    flags_nxt.warn  = LW'(residual_current) > warn_lim; // [R9] [R10] [R16]
    flags_nxt.over  = LW'(residual_current) > limit; // [R11] [R12] [R16]
    tmr_nxt         = flags_r.over ? ((&tmr_r) ? tmr_r : tmr_r + 32'h0000_0001) : 32'h0000_0000; // [R15]
    flags_nxt.alarm = (flags_r.over && (tmr_r > min_r)) || (flags_r.alarm && !ack); // [R13] [R14]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_r <= '0;
      tmr_r   <= '0;
    end else begin
      flags_r <= flags_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  // ****************************************
  // apb slave and interrupt
  // ****************************************
  always_comb begin
    mode_nxt    = mode_r;
    pct_nxt     = pct_r;
    cnt_nxt     = cnt_r;
    soff_nxt    = soff_r;
    scale_nxt   = scale_r;
    min_nxt     = min_r;
    thr_nxt     = thr_r;
    off_nxt     = off_r;
    imask_nxt   = imask_r;
    istat_nxt   = istat_r;
    prdata_nxt  = 32'h0000_0000;
    pready_nxt  = psel & penable & ~pready_r;
    pslverr_nxt = 1'b0;
    mapped      = 1'b1;
    if (wr && paddr == ADDR_INT_STAT) begin
      istat_nxt = istat_r & ~pwdata[2:0];
    end
    istat_nxt = istat_nxt | events;
    unique case (paddr)
      ADDR_CTRL:       prdata_nxt = 32'({cnt_r, pct_r, 6'h00, mode_r});
      ADDR_STATIC_OFF: prdata_nxt = 32'(soff_r);
      ADDR_SCALE:      prdata_nxt = 32'(scale_r);
      ADDR_MIN_TIME:   prdata_nxt = min_r;
      ADDR_FLAGS:      prdata_nxt = 32'(flags_r);
      ADDR_ACK:        prdata_nxt = 32'h0000_0000;
      ADDR_INT_STAT:   prdata_nxt = 32'(istat_r);
      ADDR_INT_MASK:   prdata_nxt = 32'(imask_r);
      ADDR_LIMIT:      prdata_nxt = 32'(limit);
      ADDR_WARN_LIM:   prdata_nxt = 32'(warn_lim);
      default:         mapped     = 1'b0;
    endcase
    for (int i = 0; i < N; i++) begin
      if (paddr == ADDR_THR_BASE + 8'(4 * i)) begin
        mapped     = 1'b1;
        prdata_nxt = 32'(thr_r[i]);
        if (wr) thr_nxt[i] = pwdata[RW-1:0]; // [R4]
      end
      if (paddr == ADDR_OFF_BASE + 8'(4 * i)) begin
        mapped     = 1'b1;
        prdata_nxt = 32'(off_r[i]);
        if (wr) off_nxt[i] = pwdata[LW-1:0]; // [R7]
      end
    end
    if (wr) begin
      unique case (paddr)
        ADDR_CTRL: begin
          mode_nxt = pwdata[CTRL_MODE_LSB +: 2];
          pct_nxt  = pwdata[CTRL_PCT_LSB +: 8];
          cnt_nxt  = (pwdata[CTRL_CNT_LSB +: 4] > 4'(N)) ? 4'(N) : pwdata[CTRL_CNT_LSB +: 4];
        end
        ADDR_STATIC_OFF: soff_nxt  = pwdata[LW-1:0];
        ADDR_SCALE:      scale_nxt = pwdata[15:0];
        ADDR_MIN_TIME:   min_nxt   = pwdata;
        ADDR_INT_MASK:   imask_nxt = pwdata[2:0];
        default:         ;
      endcase
    end
    irq_nxt = |(istat_nxt & imask_nxt);
    if (!psel || !penable || pready_r || pwrite) begin
      prdata_nxt = 32'h0000_0000;
    end
    if (pready_nxt && !mapped) begin
      pslverr_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r    <= RST_MODE;
      pct_r     <= RST_WARN_PCT;
      cnt_r     <= RST_STEP_CNT;
      soff_r    <= LW'(RST_STATIC_OFF);
      scale_r   <= RST_SCALE[15:0];
      min_r     <= RST_MIN_TIME;
      thr_r     <= '0;
      off_r     <= '0;
      istat_r   <= '0;
      imask_r   <= RST_INT_MASK;
      irq_r     <= 1'b0;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      pct_r     <= pct_nxt;
      cnt_r     <= cnt_nxt;
      soff_r    <= soff_nxt;
      scale_r   <= scale_nxt;
      min_r     <= min_nxt;
      thr_r     <= thr_nxt;
      off_r     <= off_nxt;
      istat_r   <= istat_nxt;
      imask_r   <= imask_nxt;
      irq_r     <= irq_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign warn_flag  = flags_r.warn;
  assign over_flag  = flags_r.over;
  assign alarm_flag = flags_r.alarm;
  assign irq        = irq_r;

  // ****************************************
  // assertions
  // ****************************************
  over_set_a: assert property (@(posedge core_clk) disable iff (rst) // [R11]
    (LW'(residual_current) > limit) |=> over_flag)
    else $error("overcurrent flag missed");

  over_clear_a: assert property (@(posedge core_clk) disable iff (rst) // [R12]
    (LW'(residual_current) <= limit) |=> !over_flag)
    else $error("overcurrent flag stuck");

  warn_set_a: assert property (@(posedge core_clk) disable iff (rst) // [R9]
    (LW'(residual_current) > warn_lim) |=> warn_flag)
    else $error("warning flag missed");

  warn_clear_a: assert property (@(posedge core_clk) disable iff (rst) // [R10]
    (LW'(residual_current) <= warn_lim) |=> !warn_flag)
    else $error("warning flag stuck");

  alarm_delay_a: assert property (@(posedge core_clk) disable iff (rst) // [R13]
    $rose(alarm_flag) |-> $past(over_flag, 1) && $past(over_flag, 2) && ($past(tmr_r) > $past(min_r)))
    else $error("alarm without long exceedance");

  alarm_latch_a: assert property (@(posedge core_clk) disable iff (rst) // [R14]
    (alarm_flag && !ack) |=> alarm_flag)
    else $error("alarm dropped without acknowledge");

  timer_restart_a: assert property (@(posedge core_clk) disable iff (rst) // [R15]
    !over_flag |=> (tmr_r == 32'h0000_0000))
    else $error("timer not restarted");

  static_limit_a: assert property (@(posedge core_clk) disable iff (rst) // [R1]
    (!rst && mode_r == MODE_STATIC) ##1 (mode_r == MODE_STATIC) |-> (limit == $past(soff_r)))
    else $error("static limit wrong");

  step_empty_a: assert property (@(posedge core_clk) disable iff (rst) // [R6]
    (mode_r == MODE_STEP && cnt_r == 4'h0) ##1 (mode_r == MODE_STEP) |-> (limit == $past(soff_r)))
    else $error("empty table limit wrong");

  irq_level_a: assert property (@(posedge core_clk) disable iff (rst)
    irq_r == (|(istat_r & imask_r)))
    else $error("interrupt level wrong");

  apb_ready_a: assert property (@(posedge core_clk) disable iff (rst)
    (psel && penable && !pready_r) |=> pready_r)
    else $error("apb answer late");

  ready_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    pready |=> !pready)
    else $error("apb ready held");

  slverr_ready_a: assert property (@(posedge core_clk) disable iff (rst)
    pslverr |-> pready)
    else $error("apb error without ready");

  rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !pready |-> (prdata == 32'h0000_0000))
    else $error("read data outside answer");

  timer_count_a: assert property (@(posedge core_clk) disable iff (rst) // [R13]
    (over_flag && !(&tmr_r)) |=> (tmr_r == $past(tmr_r) + 32'h0000_0001))
    else $error("exceedance timer not counting");

  warn_below_a: assert property (@(posedge core_clk) disable iff (rst) // [R8]
    (pct_r <= 8'h64) |=> (warn_lim <= limit))
    else $error("warning limit above limit");

  ack_clear_a: assert property (@(posedge core_clk) disable iff (rst) // [R14]
    (ack && !over_flag) |=> !alarm_flag)
    else $error("alarm kept after acknowledge");

  alarm_rise_c: cover property (@(posedge core_clk) disable iff (rst) $rose(alarm_flag));
  short_over_c: cover property (@(posedge core_clk) disable iff (rst) $fell(over_flag) && !alarm_flag);
  ack_clear_c:  cover property (@(posedge core_clk) disable iff (rst) $fell(alarm_flag));
  step_mode_c:  cover property (@(posedge core_clk) disable iff (rst) (mode_r == MODE_STEP) && over_flag);
  dyn_mode_c:   cover property (@(posedge core_clk) disable iff (rst) (mode_r == MODE_DYNAMIC) && over_flag);

endmodule : residual_current_monitor

// [testbench/rcm_meas_model.sv]
`timescale 1ns/1ps
// ****************************************
// measurement source: sensors update each clock
// ****************************************
module rcm_meas_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [15:0] cur_set,
  input  wire logic [15:0] ref_set,
  output logic      [15:0] residual_current,
  output logic      [15:0] reference_value
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      residual_current <= 16'h0000;
      reference_value  <= 16'h0000;
    end else begin
      residual_current <= cur_set;
      reference_value  <= ref_set;
    end
  end
endmodule : rcm_meas_model

// [testbench/residual_current_monitor_tb.sv]
`timescale 1ns/1ps
module residual_current_monitor_tb;
  import rcm_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [15:0] cur_set  = 16'h0000;
  logic [15:0] ref_set  = 16'h0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [15:0] residual_current;
  logic [15:0] reference_value;
  logic        warn_flag;
  logic        over_flag;
  logic        alarm_flag;
  logic        irq;
  int          fails    = 0;
  int          checked  = 0;
  int          cyc      = 0;

  always #25 core_clk = ~core_clk;

  rcm_meas_model meas_u (.core_clk(core_clk), .rst(rst), .cur_set(cur_set), .ref_set(ref_set),
                         .residual_current(residual_current), .reference_value(reference_value));

  residual_current_monitor dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .residual_current(residual_current), .reference_value(reference_value),
    .warn_flag(warn_flag), .over_flag(over_flag), .alarm_flag(alarm_flag), .irq(irq));

  // ****************************************
  // checking and closing
  // ****************************************
  task results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task chkf(input string nm, input flags_t exp);
    flags_t got;
    got = '{alarm: alarm_flag, over: over_flag, warn: warn_flag};
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %b seen %b", nm, exp, got);
    end
  endtask : chkf

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  // ****************************************
  // apb master and stimulus helpers
  // ****************************************
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask : rdchk

  task meas(input logic [15:0] c, input logic [15:0] r);
    @(posedge core_clk);
    cur_set <= c;
    ref_set <= r;
    repeat (5) @(posedge core_clk);
  endtask : meas

  task over_for(input int n);
    @(posedge core_clk);
    cur_set <= 16'h012D;
    repeat (n) @(posedge core_clk);
    cur_set <= 16'h0000;
    repeat (2) @(posedge core_clk);
  endtask : over_for

  function automatic logic [31:0] ctrl(input logic [1:0] m, input logic [7:0] p, input logic [3:0] c);
    return {12'h000, c, p, 6'h00, m};
  endfunction : ctrl

  function automatic logic [31:0] soff(input int i);
    return (i % 2) ? 32'(10 * i) : 32'(500 + i);
  endfunction : soff

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdchk("limit_rst", ADDR_LIMIT, 32'h0000_012C);
    rdchk("warn_rst", ADDR_WARN_LIM, 32'h0000_00F0);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, {31'h0, err});
    chk("unmapped_data", 32'h0000_0000, rd);
    wr(ADDR_LIMIT, 32'h0000_0001);
    rdchk("limit_ro", ADDR_LIMIT, 32'h0000_012C);
    wr(ADDR_INT_MASK, 32'h0000_0007);
    wr(ADDR_MIN_TIME, 32'h0000_00FF);
    meas(16'h00F0, 16'hFFFF); chkf("at_warn", 3'b000);
    meas(16'h00F1, 16'h0003); chkf("above_warn", 3'b001);
    chk("irq_on", 32'h0000_0001, {31'h0, irq});
    meas(16'h012C, 16'h0000); chkf("at_limit", 3'b001);
    meas(16'h012D, 16'h0000); chkf("over", 3'b011);
    meas(16'h012C, 16'h0000); chkf("over_end", 3'b001);
    meas(16'h00F0, 16'h0000); chkf("warn_end", 3'b000);
    rdchk("int_stat", ADDR_INT_STAT, 32'h0000_0003);
    wr(ADDR_INT_STAT, 32'h0000_0001);
    rdchk("int_w1c", ADDR_INT_STAT, 32'h0000_0002);
    wr(ADDR_INT_MASK, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    chk("irq_mask", 32'h0000_0000, {31'h0, irq});
    wr(ADDR_INT_STAT, 32'h0000_0007);
    wr(ADDR_MIN_TIME, 32'h0000_0003);
    over_for(2);
    over_for(2);
    repeat (4) @(posedge core_clk);
    chkf("short_over", 3'b000);
    over_for(10);
    meas(16'h0000, 16'h0000); chkf("alarm_kept", 3'b100);
    rdchk("flags_reg", ADDR_FLAGS, 32'h0000_0004);
    wr(ADDR_ACK, 32'h0000_0001);
    meas(16'h0000, 16'h0000); chkf("alarm_ack", 3'b000);
    wr(ADDR_MIN_TIME, 32'h0000_00FF);
    wr(ADDR_SCALE, 32'h0000_000A);
    wr(ADDR_STATIC_OFF, 32'h0000_0014);
    wr(ADDR_CTRL, ctrl(MODE_DYNAMIC, 8'h32, 4'h0));
    meas(16'h0047, 16'h0005); chkf("dyn_over", 3'b011);
    rdchk("dyn_limit", ADDR_LIMIT, 32'h0000_0046);
    rdchk("dyn_warn", ADDR_WARN_LIM, 32'h0000_0023);
    meas(16'h0047, 16'h0008); chkf("dyn_track", 3'b001);
    rdchk("dyn_limit2", ADDR_LIMIT, 32'h0000_0064);
    wr(ADDR_STATIC_OFF, 32'h0000_0064);
    wr(ADDR_CTRL, ctrl(MODE_STEP, 8'h50, 4'h0));
    meas(16'h0000, 16'hFFFF);
    rdchk("step_none", ADDR_LIMIT, 32'h0000_0064);
    for (int i = 0; i < 10; i++) begin
      wr(ADDR_THR_BASE + 8'(4 * i), 32'(10 * (i + 1)));
      wr(ADDR_OFF_BASE + 8'(4 * i), soff(i));
    end
    wr(ADDR_CTRL, ctrl(MODE_STEP, 8'h50, 4'h3));
    meas(16'h006F, 16'h0019); chkf("step_over", 3'b011);
    rdchk("step_mid", ADDR_LIMIT, 32'h0000_0064 + soff(1));
    meas(16'h0000, 16'h001E);
    rdchk("step_equal", ADDR_LIMIT, 32'h0000_0064 + soff(1));
    meas(16'h0000, 16'h001F);
    rdchk("step_next", ADDR_LIMIT, 32'h0000_0064 + soff(2));
    rdchk("step_warn", ADDR_WARN_LIM, 32'h0000_01E1);
    meas(16'h0000, 16'h00C8);
    rdchk("step_cnt", ADDR_LIMIT, 32'h0000_0064 + soff(2));
    meas(16'h0000, 16'h0005);
    rdchk("step_below", ADDR_LIMIT, 32'h0000_0064);
    wr(ADDR_CTRL, ctrl(MODE_STEP, 8'h50, 4'hF));
    rdchk("ctrl_clip", ADDR_CTRL, ctrl(MODE_STEP, 8'h50, 4'hA));
    meas(16'h0000, 16'h00C8);
    rdchk("step_ten", ADDR_LIMIT, 32'h0000_0064 + soff(9));
    results();
  end
endmodule : residual_current_monitor_tb
